// file: acd_pkg.sv
package acd_pkg;

	// -------------------------------------------------------------
	// command byte decode
	// -------------------------------------------------------------
	localparam int         ACD_CONV_TAG_BIT  = 7;
	localparam int         ACD_SETUP_TAG_BIT = 6;
	localparam int         ACD_AVG_TAG_BIT   = 5;
	localparam int         ACD_RST_TAG_BIT   = 4;
	localparam int         ACD_FIFO_ONLY_BIT = 3;
	localparam int         ACD_TEMP_BIT      = 0;
	localparam int         ACD_AVG_EN_BIT    = 4;

	// -------------------------------------------------------------
	// values after reset
	// -------------------------------------------------------------
	localparam logic [7:0] ACD_CONV_RST  = 8'h00;
	localparam logic [7:0] ACD_SETUP_RST = 8'h20;
	localparam logic [7:0] ACD_AVG_RST   = 8'h00;
	localparam logic [7:0] ACD_PAIR_RST  = 8'h00;
	localparam logic [3:0] ACD_SYNC_RST  = 4'hC;

	// -------------------------------------------------------------
	// modes
	// -------------------------------------------------------------
	localparam logic [1:0] ACD_SCAN_LOW    = 2'h0;
	localparam logic [1:0] ACD_SCAN_HIGH   = 2'h1;
	localparam logic [1:0] ACD_SCAN_REPEAT = 2'h2;
	localparam logic [1:0] ACD_SCAN_ONCE   = 2'h3;
	localparam logic [1:0] ACD_CK_SCLK     = 2'h3;
	localparam logic [1:0] ACD_REF_EXT_DIF = 2'h3;

	// -------------------------------------------------------------
	// channels, counts and result word
	// -------------------------------------------------------------
	localparam logic [3:0] ACD_CONVERT_START_PIN_CH   = 4'hF;
	localparam logic [3:0] ACD_REFN_CH    = 4'hE;
	localparam logic [3:0] ACD_TOP_CH     = 4'hF;
	localparam logic [5:0] ACD_ONE_SAMPLE = 6'h01;
	localparam logic [5:0] ACD_MIN_AVG    = 6'h04;
	localparam logic [3:0] ACD_LEAD_ZEROS = 4'h0;
	localparam logic [3:0] ACD_LAST_BIT   = 4'hF;
	localparam logic [2:0] ACD_BYTE_LAST  = 3'h7;

	// -------------------------------------------------------------
	// scan sequencer states
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		ACD_IDLE = 4'h1,
		ACD_TEMP = 4'h2,
		ACD_PICK = 4'h4,
		ACD_CONV = 4'h8
	} acd_state_e;

endpackage

// file: acd_top.sv
// Operation
// R1: byte with MSB set writes conversion register: channel, scan mode, temperature.
// R2: byte starting 01 writes setup: clock mode, reference mode, pairing target.
// R3: byte starting 001 writes averaging: enable, samples per result, repeat count.
// R4: byte starting 0001 with bit 3 set clears only the result FIFO.
// R5: reset byte with bit 3 clear restores every register and the device.
// R6: scan modes: 0..N, N..top, N repeated, N once.
// R7: range scans give one result per single channel or pair, plus temperature.
// R8: temperature request yields one measurement per scan, delivered first.
// R9: scan starts on conversion write in clock modes 1x, pin pulse in 0x.
// R10: channels serving as convert-start or negative reference are not converted.
// R11: a pair with either member reassigned to those pins is skipped.
// R12: host addresses a pair by its lower channel number.
// R13: host avoids channels that the smaller variants lack.
// R14: pairing target 10 sends next byte to unipolar, 11 to bipolar.
// R15: host holds select low for sixteen clocks around setup plus pairing byte.
// R16: pairing target 00 or 01 leaves pairing registers; next byte is a command.
// R17: pair marked both unipolar and bipolar is treated as unipolar.
// R18: unipolar results straight binary, bipolar pairs two's complement.
// R19: with averaging on, up to 32 samples per result in all scan modes.
// R20: clock mode 11 never averages.
// R21: power-up registers zero except setup clock mode field at 10.
// R22: every functional block, reference included, starts in shutdown.
// R23: clock mode decode: pin timed, pin acquisition, command timed, serial clock.
// R24: results read as two bytes, four zero bits then twelve bits, MSB first.
// R25: byte with upper nibble zero is ignored.
module acd_top
	import acd_pkg::*;
(
	// system
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// serial link
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        sdi_i,
	output logic             sdo_o,
	// convert-start pin
	input  wire logic        convst_n_i,
	// conversion engine
	output logic             conv_req_o,
	output logic [3:0]       conv_ch_o,
	output logic             conv_diff_o,
	output logic             conv_twos_o,
	output logic             conv_temp_o,
	output logic [5:0]       conv_samples_o,
	input  wire logic        conv_ack_i,
	// result fifo
	input  wire logic [11:0] fifo_word_i,
	output logic             fifo_pop_o,
	output logic             fifo_clear_o,
	// status
	output logic             shutdown_o,
	output logic             scan_busy_o,
	output logic [1:0]       clock_mode_o,
	output logic [1:0]       ref_mode_o
);

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	// -------------------------------------------------------------
	// link receive, serial clock domain
	// -------------------------------------------------------------
	logic       link_rst;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [6:0] shift_r,   shift_nxt;
	logic       rx_tgl_r,  rx_tgl_nxt;
	logic [7:0] slot_r   [2];
	logic [7:0] slot_nxt [2];

	assign link_rst = reset_i | cs_n_i;

	always_comb begin
		bit_cnt_nxt = bit_cnt_r + 3'd1;
		shift_nxt   = {shift_r[5:0], sdi_i};
		rx_tgl_nxt  = rx_tgl_r;
		slot_nxt    = slot_r;
		// bytes alternate between two slots so one can be read while the next fills
		if (bit_cnt_r == ACD_BYTE_LAST) begin
			slot_nxt[rx_tgl_r] = {shift_r, sdi_i};
			rx_tgl_nxt         = ~rx_tgl_r;
		end
	end

	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt_r <= 3'h0;
			shift_r   <= 7'h00;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			shift_r   <= shift_nxt;
		end
	end

	always_ff @(posedge sclk_i or posedge reset_i) begin
		if (reset_i) begin
			rx_tgl_r  <= 1'b0;
			slot_r[0] <= 8'h00;
			slot_r[1] <= 8'h00;
		end else begin
			rx_tgl_r  <= rx_tgl_nxt;
			slot_r    <= slot_nxt;
		end
	end

	// -------------------------------------------------------------
	// link transmit, falling serial clock edge
	// -------------------------------------------------------------
	logic [3:0]  tx_idx_r,  tx_idx_nxt;
	logic [15:0] tx_word_r, tx_word_nxt;
	logic        sdo_r,     sdo_nxt;
	logic        pop_tgl_r, pop_tgl_nxt;

	always_comb begin
		tx_idx_nxt  = tx_idx_r + 4'h1;
		tx_word_nxt = tx_word_r;
		pop_tgl_nxt = pop_tgl_r;
		// word taken on the first falling edge while a leading zero goes out
		if (tx_idx_r == 4'h0) begin
			tx_word_nxt = {ACD_LEAD_ZEROS, fifo_word_i}; // [R24]
			pop_tgl_nxt = ~pop_tgl_r;
		end
		sdo_nxt = tx_word_r[ACD_LAST_BIT - tx_idx_nxt]; // [R24]
	end

	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			tx_idx_r  <= 4'h0;
			tx_word_r <= 16'h0000;
			sdo_r     <= 1'b0;
		end else begin
			tx_idx_r  <= tx_idx_nxt;
			tx_word_r <= tx_word_nxt;
			sdo_r     <= sdo_nxt;
		end
	end

	always_ff @(negedge sclk_i or posedge reset_i) begin
		if (reset_i) begin
			pop_tgl_r <= 1'b0;
		end else begin
			pop_tgl_r <= pop_tgl_nxt;
		end
	end

	assign sdo_o = sdo_r;

	// -------------------------------------------------------------
	// crossings into system clock: {cs_n, convst_n, pop, rx}
	// -------------------------------------------------------------
	logic [3:0] sync1_r, sync2_r, sync3_r, flt_r, flt_nxt;
	logic       rx_ev, pop_ev, cs_high, convst_fall;
	logic [7:0] rx_byte;
	logic       pop_r;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			flt_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : flt_r[i];
		end
		rx_ev       = flt_nxt[0] ^ flt_r[0];
		pop_ev      = flt_nxt[1] ^ flt_r[1];
		convst_fall = flt_r[2] & ~flt_nxt[2];
		cs_high     = flt_r[3];
		rx_byte     = slot_r[flt_r[0]];
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_r <= ACD_SYNC_RST;
			sync2_r <= ACD_SYNC_RST;
			sync3_r <= ACD_SYNC_RST;
			flt_r   <= ACD_SYNC_RST;
			pop_r   <= 1'b0;
		end else begin
			sync1_r <= {cs_n_i, convst_n_i, pop_tgl_r, rx_tgl_r};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			flt_r   <= flt_nxt;
			pop_r   <= pop_ev;
		end
	end

	assign fifo_pop_o = pop_r;

	// -------------------------------------------------------------
	// command decode and registers
	// -------------------------------------------------------------
	logic [7:0] conv_r,  conv_nxt;
	logic [7:0] setup_r, setup_nxt;
	logic [7:0] avg_r,   avg_nxt;
	logic [7:0] uni_r,   uni_nxt;
	logic [7:0] bip_r,   bip_nxt;
	logic [1:0] pend_r,  pend_nxt;
	logic       clear_r, clear_nxt;
	logic       soft_rst, start_cmd;

	always_comb begin
		conv_nxt  = conv_r;
		setup_nxt = setup_r;
		avg_nxt   = avg_r;
		uni_nxt   = uni_r;
		bip_nxt   = bip_r;
		pend_nxt  = pend_r;
		clear_nxt = 1'b0;
		soft_rst  = 1'b0;
		start_cmd = 1'b0;
		if (rx_ev) begin
			if (pend_r[1]) begin
				if (pend_r[0]) begin
					bip_nxt = rx_byte; // [R14]
				end else begin
					uni_nxt = rx_byte; // [R14]
				end
				pend_nxt = 2'h0;
			end else if (rx_byte[ACD_CONV_TAG_BIT]) begin
				conv_nxt  = rx_byte; // [R1]
				start_cmd = 1'b1;
			end else if (rx_byte[ACD_SETUP_TAG_BIT]) begin
				setup_nxt = rx_byte; // [R2]
				pend_nxt  = rx_byte[1] ? {1'b1, rx_byte[0]} : 2'h0; // [R14] [R16]
			end else if (rx_byte[ACD_AVG_TAG_BIT]) begin
				avg_nxt = rx_byte; // [R3]
			end else if (rx_byte[ACD_RST_TAG_BIT]) begin
				clear_nxt = 1'b1; // [R4]
				soft_rst  = ~rx_byte[ACD_FIFO_ONLY_BIT]; // [R5]
			end
			// upper nibble zero falls through untouched [R25]
		end else if (cs_high) begin
			pend_nxt = 2'h0;
		end
		if (soft_rst) begin
			conv_nxt  = ACD_CONV_RST; // [R5] [R21]
			setup_nxt = ACD_SETUP_RST;
			avg_nxt   = ACD_AVG_RST;
			uni_nxt   = ACD_PAIR_RST;
			bip_nxt   = ACD_PAIR_RST;
			pend_nxt  = 2'h0;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			conv_r  <= ACD_CONV_RST; // [R21]
			setup_r <= ACD_SETUP_RST;
			avg_r   <= ACD_AVG_RST;
			uni_r   <= ACD_PAIR_RST;
			bip_r   <= ACD_PAIR_RST;
			pend_r  <= 2'h0;
			clear_r <= 1'b0;
		end else begin
			conv_r  <= conv_nxt;
			setup_r <= setup_nxt;
			avg_r   <= avg_nxt;
			uni_r   <= uni_nxt;
			bip_r   <= bip_nxt;
			pend_r  <= pend_nxt;
			clear_r <= clear_nxt;
		end
	end

	assign fifo_clear_o = clear_r;
	assign clock_mode_o = setup_r[5:4];
	assign ref_mode_o   = setup_r[3:2];

	// -------------------------------------------------------------
	// scan sequencer
	// -------------------------------------------------------------
	function automatic logic ch_rsv(input logic [3:0] c, input logic [1:0] ck,
		input logic [1:0] rf);
		ch_rsv = (c == ACD_CONVERT_START_PIN_CH && !ck[1]) || (c == ACD_REFN_CH && rf == ACD_REF_EXT_DIF);
	endfunction

	acd_state_e state_r, state_nxt;
	logic [4:0] cur_r,   cur_nxt;
	logic [3:0] last_r,  last_nxt;
	logic [5:0] reps_r,  reps_nxt;
	logic       range_r, range_nxt;
	logic [3:0] ch_r,    ch_nxt;
	logic       diff_r,  diff_nxt;
	logic       twos_r,  twos_nxt;
	logic       temp_r,  temp_nxt;
	logic [5:0] smp_r,   smp_nxt;
	logic       shd_r,   shd_nxt;
	logic       trig, uflag, bflag, paired, skip;
	logic [1:0] scan;
	logic [3:0] base;
	logic [2:0] rep_n;

	always_comb begin
		state_nxt = state_r;
		cur_nxt   = cur_r;
		last_nxt  = last_r;
		reps_nxt  = reps_r;
		range_nxt = range_r;
		ch_nxt    = ch_r;
		diff_nxt  = diff_r;
		twos_nxt  = twos_r;
		temp_nxt  = temp_r;
		smp_nxt   = smp_r;
		shd_nxt   = shd_r;
		trig = (start_cmd & setup_r[5]) | (convst_fall & ~setup_r[5]); // [R9] [R23]
		scan = (setup_r[5:4] == ACD_CK_SCLK) ? ACD_SCAN_ONCE : conv_nxt[2:1]; // [R23]
		rep_n = {1'b0, avg_r[1:0]} + 3'd1;
		base  = {cur_r[3:1], 1'b0}; // [R12]
		uflag = uni_r[3'd7 - cur_r[3:1]];
		bflag = bip_r[3'd7 - cur_r[3:1]];
		paired = uflag | bflag;
		skip = paired ? (ch_rsv(base, setup_r[5:4], setup_r[3:2])
			| ch_rsv(base | 4'h1, setup_r[5:4], setup_r[3:2])
			| (cur_r[0] & range_r)) // [R7] [R11]
			: ch_rsv(cur_r[3:0], setup_r[5:4], setup_r[3:2]); // [R10]
		case (state_r)
			ACD_IDLE: begin
				if (trig) begin
					cur_nxt   = (scan == ACD_SCAN_LOW) ? 5'h00 : {1'b0, conv_nxt[6:3]}; // [R6]
					last_nxt  = (scan == ACD_SCAN_HIGH) ? ACD_TOP_CH : conv_nxt[6:3];
					reps_nxt  = (scan == ACD_SCAN_REPEAT) ? {1'b0, rep_n, 2'h0} : 6'h01;
					range_nxt = ~scan[1]; // [R7]
					smp_nxt   = (avg_r[ACD_AVG_EN_BIT] && setup_r[5:4] != ACD_CK_SCLK) ?
						6'(ACD_MIN_AVG << avg_r[3:2]) : ACD_ONE_SAMPLE; // [R19] [R20]
					shd_nxt   = 1'b0;
					if (conv_nxt[ACD_TEMP_BIT]) begin
						temp_nxt  = 1'b1; // [R8]
						state_nxt = ACD_TEMP;
					end else begin
						state_nxt = ACD_PICK;
					end
				end
			end
			ACD_TEMP: begin
				if (conv_ack_i) begin
					temp_nxt  = 1'b0;
					state_nxt = ACD_PICK;
				end
			end
			ACD_PICK: begin
				if (cur_r > {1'b0, last_r}) begin
					shd_nxt   = 1'b1; // [R22]
					state_nxt = ACD_IDLE;
				end else if (skip) begin
					cur_nxt = cur_r + 5'h01;
				end else begin
					ch_nxt    = paired ? base : cur_r[3:0];
					diff_nxt  = paired;
					twos_nxt  = bflag & ~uflag; // [R17] [R18]
					state_nxt = ACD_CONV;
				end
			end
			ACD_CONV: begin
				if (conv_ack_i) begin
					if (reps_r > 6'h01) begin
						reps_nxt = reps_r - 6'h01; // [R6]
					end else begin
						cur_nxt = cur_r + 5'h01;
					end
					state_nxt = ACD_PICK;
				end
			end
			default: begin
				state_nxt = ACD_IDLE;
			end
		endcase
		if (soft_rst) begin
			state_nxt = ACD_IDLE; // [R5]
			temp_nxt  = 1'b0;
			shd_nxt   = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ACD_IDLE;
			cur_r   <= 5'h00;
			last_r  <= 4'h0;
			reps_r  <= 6'h01;
			range_r <= 1'b0;
			ch_r    <= 4'h0;
			diff_r  <= 1'b0;
			twos_r  <= 1'b0;
			temp_r  <= 1'b0;
			smp_r   <= ACD_ONE_SAMPLE;
			shd_r   <= 1'b1; // [R22]
		end else begin
			state_r <= state_nxt;
			cur_r   <= cur_nxt;
			last_r  <= last_nxt;
			reps_r  <= reps_nxt;
			range_r <= range_nxt;
			ch_r    <= ch_nxt;
			diff_r  <= diff_nxt;
			twos_r  <= twos_nxt;
			temp_r  <= temp_nxt;
			smp_r   <= smp_nxt;
			shd_r   <= shd_nxt;
		end
	end

	assign conv_req_o     = (state_r == ACD_CONV) || (state_r == ACD_TEMP);
	assign conv_ch_o      = ch_r;
	assign conv_diff_o    = diff_r;
	assign conv_twos_o    = twos_r;
	assign conv_temp_o    = temp_r;
	assign conv_samples_o = smp_r;
	assign shutdown_o     = shd_r;
	assign scan_busy_o    = (state_r != ACD_IDLE);

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	conv_write_a: assert property (rx_ev && !pend_r[1] && rx_byte[7] |=> conv_r == $past(rx_byte)) // [R1]
		else $error("conversion write not stored");
	setup_write_a: assert property (rx_ev && !pend_r[1] && rx_byte[7:6] == 2'h1
		|=> setup_r == $past(rx_byte)) // [R2]
		else $error("setup write not stored");
	avg_write_a: assert property (rx_ev && !pend_r[1] && rx_byte[7:5] == 3'h1
		|=> avg_r == $past(rx_byte)) // [R3]
		else $error("averaging write not stored");
	fifo_only_a: assert property (rx_ev && !pend_r[1] && rx_byte[7:3] == 5'h03
		|=> fifo_clear_o && $stable(setup_r) && $stable(uni_r)) // [R4]
		else $error("fifo clear touched registers");
	full_reset_a: assert property (rx_ev && !pend_r[1] && rx_byte[7:3] == 5'h02
		|=> setup_r == ACD_SETUP_RST && conv_r == ACD_CONV_RST && shutdown_o) // [R5]
		else $error("full reset incomplete");
	pair_write_a: assert property (rx_ev && pend_r == 2'h2
		|=> uni_r == $past(rx_byte) && pend_r == 2'h0) // [R14]
		else $error("unipolar pairing byte lost");
	no_pair_a: assert property (rx_ev && !pend_r[1] && rx_byte[7:6] == 2'h1 && !rx_byte[1]
		|=> pend_r == 2'h0 ##1 $stable(uni_r) && $stable(bip_r)) // [R16]
		else $error("pairing written without target");
	ignore_cmd_a: assert property (rx_ev && !pend_r[1] && rx_byte[7:4] == 4'h0
		|=> $stable(conv_r) && $stable(setup_r) && $stable(avg_r) && !fifo_clear_o) // [R25]
		else $error("null command changed state");
	pin_skip_a: assert property (conv_req_o && !conv_temp_o && !clock_mode_o[1]
		|-> conv_ch_o != ACD_CONVERT_START_PIN_CH && !(conv_diff_o && conv_ch_o == ACD_REFN_CH)) // [R10]
		else $error("convert-start channel converted");
	temp_first_a: assert property (state_r == ACD_IDLE && trig && conv_nxt[0]
		|=> conv_req_o && conv_temp_o) // [R8]
		else $error("temperature not first");
	cmd_start_a: assert property (start_cmd && setup_r[5] && state_r == ACD_IDLE
		|=> scan_busy_o && !shutdown_o) // [R9]
		else $error("command did not start scan");
	no_avg_a: assert property (conv_req_o && clock_mode_o == ACD_CK_SCLK
		|-> conv_samples_o == ACD_ONE_SAMPLE) // [R20]
		else $error("averaging in serial clock mode");
	uni_wins_a: assert property (conv_req_o && conv_diff_o && uni_r[3'd7 - conv_ch_o[3:1]]
		|-> !conv_twos_o) // [R17]
		else $error("bipolar over unipolar");

endmodule

// file: acd_host_model.sv
module acd_host_model (
	// serial link
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------
	// link idles with clock stopped low and select high
	// ---------------------------------------------------------
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end

	// ---------------------------------------------------------
	// one byte, msb first, data set just after the falling edge
	// ---------------------------------------------------------
	task automatic shift_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sdi_o = b[i];
			#15 sclk_o = 1'b1;
			#15 sclk_o = 1'b0;
		end
		// clock held still so the slow domain sees each byte
		#600;
	endtask

	// ---------------------------------------------------------
	// one frame of one or two bytes
	// ---------------------------------------------------------
	task automatic send(input logic [7:0] b0, input logic [7:0] b1, input int n);
		#7 cs_n_o = 1'b0;
		#20;
		shift_byte(b0);
		if (n > 1) begin
			shift_byte(b1);
		end
		cs_n_o = 1'b1;
		// released data line must not keep its last value
		sdi_o  = ~sdi_o;
		#300;
	endtask

	// ---------------------------------------------------------
	// one 16-bit result word, sampled on the rising edge
	// ---------------------------------------------------------
	task automatic read_word(output logic [15:0] w);
		#7 cs_n_o = 1'b0;
		// data line low so the bytes clocked in meanwhile decode as null commands
		sdi_o  = 1'b0;
		#50;
		for (int i = 15; i >= 0; i--) begin
			#15 sclk_o = 1'b1;
			w[i] = sdo_i;
			#15 sclk_o = 1'b0;
		end
		#1000 cs_n_o = 1'b1;
		sdi_o  = ~sdi_o;
		#300;
	endtask
endmodule

// file: tb_adc_serial_command_decoder.sv
module tb_adc_serial_command_decoder;
	import acd_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	// ---------------------------------------------------------
	// signals
	// ---------------------------------------------------------
	logic        clk_sys_i;
	logic        reset_i;
	logic        sclk_i;
	logic        cs_n_i;
	logic        sdi_i;
	logic        sdo_o;
	logic        convst_n_i;
	logic        conv_req_o;
	logic [3:0]  conv_ch_o;
	logic        conv_diff_o;
	logic        conv_twos_o;
	logic        conv_temp_o;
	logic [5:0]  conv_samples_o;
	logic        conv_ack_i = 1'b0;
	logic [11:0] fifo_word_i;
	logic        fifo_pop_o;
	logic        fifo_clear_o;
	logic        shutdown_o;
	logic        scan_busy_o;
	logic [1:0]  clock_mode_o;
	logic [1:0]  ref_mode_o;
	logic        req_s;
	logic [15:0] cur_s;
	logic [15:0] log_q[$];
	logic [15:0] exp_q[$];
	logic [15:0] word;
	int          ack_delay;
	int          wait_n;
	int          clears;
	int          pops;
	int          c0;
	int          fail_count;
	int          checks;

	acd_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
		.sdi_i(sdi_i), .sdo_o(sdo_o), .convst_n_i(convst_n_i), .conv_req_o(conv_req_o),
		.conv_ch_o(conv_ch_o), .conv_diff_o(conv_diff_o), .conv_twos_o(conv_twos_o),
		.conv_temp_o(conv_temp_o), .conv_samples_o(conv_samples_o), .conv_ack_i(conv_ack_i),
		.fifo_word_i(fifo_word_i), .fifo_pop_o(fifo_pop_o), .fifo_clear_o(fifo_clear_o),
		.shutdown_o(shutdown_o), .scan_busy_o(scan_busy_o), .clock_mode_o(clock_mode_o),
		.ref_mode_o(ref_mode_o));

	acd_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i), .sdo_i(sdo_o));

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// ---------------------------------------------------------
	// conversion engine and pulse monitors
	// ---------------------------------------------------------
	function automatic logic [15:0] ent(input logic d, input logic b, input logic [3:0] c,
		input logic [5:0] s);
		return {4'h0, d, b, c, s};
	endfunction

	always @(negedge clk_sys_i) begin
		req_s = conv_req_o;
		cur_s = (conv_temp_o === 1'b1) ? 16'h8000 :
			ent(conv_diff_o, conv_twos_o, conv_ch_o, conv_samples_o);
		if (fifo_clear_o === 1'b1) clears++;
		if (fifo_pop_o === 1'b1) pops++;
	end

	always @(posedge clk_sys_i) begin
		conv_ack_i <= 1'b0;
		if (req_s === 1'b1 && conv_ack_i !== 1'b1) begin
			if (wait_n == 0) begin
				conv_ack_i <= 1'b1;
				log_q.push_back(cur_s);
				wait_n = ack_delay;
			end else begin
				wait_n--;
			end
		end
	end

	// ---------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------
	task automatic final_report();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic w1(input logic [7:0] b);
		host.send(b, 8'h00, 1);
	endtask

	task automatic w2(input logic [7:0] a, input logic [7:0] b);
		host.send(a, b, 2);
	endtask

	task automatic pin_pulse();
		@(posedge clk_sys_i);
		convst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		convst_n_i <= 1'b1;
	endtask

	task automatic expect_scan();
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge clk_sys_i);
			if (log_q.size() >= exp_q.size() && scan_busy_o === 1'b0) break;
		end
		if (n == 3000) begin
			fail_count++;
			$display("Error scan end expected idle seen busy");
			final_report();
		end
		repeat (20) @(posedge clk_sys_i);
		chk("result count", 16'(exp_q.size()), 16'(log_q.size()));
		chk("shutdown", 16'h0001, 16'(shutdown_o));
		for (int i = 0; i < exp_q.size() && i < log_q.size(); i++) chk("result", exp_q[i], log_q[i]);
		log_q.delete();
	endtask

	// ---------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------
	task automatic t_reset();
		chk("clock mode", 16'h0002, 16'(clock_mode_o));
		chk("ref mode", 16'h0000, 16'(ref_mode_o));
		chk("shutdown", 16'h0001, 16'(shutdown_o));
		chk("busy", 16'h0000, 16'(scan_busy_o));
		chk("samples", 16'h0001, 16'(conv_samples_o));
	endtask

	task automatic t_range_temp();
		w1(8'h64);
		chk("ref mode", 16'h0001, 16'(ref_mode_o));
		chk("clock mode", 16'h0002, 16'(clock_mode_o));
		w1(8'h99);
		exp_q = '{16'h8000, ent(0, 0, 4'h0, 6'h01), ent(0, 0, 4'h1, 6'h01),
			ent(0, 0, 4'h2, 6'h01), ent(0, 0, 4'h3, 6'h01)};
		expect_scan();
	endtask

	task automatic t_pairing();
		ack_delay = 3;
		wait_n = 3;
		w2(8'h66, 8'hC0);
		w2(8'h67, 8'h60);
		w1(8'hA8);
		exp_q = '{ent(1, 0, 4'h0, 6'h01), ent(1, 0, 4'h2, 6'h01), ent(1, 1, 4'h4, 6'h01)};
		expect_scan();
		ack_delay = 0;
		wait_n = 0;
		w2(8'h65, 8'h86);
		exp_q = '{ent(1, 0, 4'h0, 6'h01)};
		expect_scan();
	endtask

	task automatic t_average();
		w1(8'h3D);
		w1(8'hB4);
		exp_q = {};
		for (int i = 0; i < 8; i++) exp_q.push_back(ent(0, 0, 4'h6, 6'h20));
		expect_scan();
		w1(8'h70);
		chk("clock mode", 16'h0003, 16'(clock_mode_o));
		w1(8'hB4);
		exp_q = '{ent(0, 0, 4'h6, 6'h01)};
		expect_scan();
	endtask

	task automatic t_pin();
		w1(8'h40);
		chk("clock mode", 16'h0000, 16'(clock_mode_o));
		w1(8'hEA);
		exp_q = {};
		expect_scan();
		pin_pulse();
		exp_q = '{ent(0, 0, 4'hD, 6'h20), ent(0, 0, 4'hE, 6'h20)};
		expect_scan();
		w2(8'h4E, 8'h01);
		chk("ref mode", 16'h0003, 16'(ref_mode_o));
		pin_pulse();
		exp_q = '{ent(0, 0, 4'hD, 6'h20)};
		expect_scan();
		w1(8'h5C);
		chk("clock mode", 16'h0001, 16'(clock_mode_o));
		pin_pulse();
		exp_q = '{ent(0, 0, 4'hD, 6'h20)};
		expect_scan();
	endtask

	task automatic t_reset_cmds();
		w1(8'h05);
		chk("clock mode", 16'h0001, 16'(clock_mode_o));
		chk("ref mode", 16'h0003, 16'(ref_mode_o));
		c0 = clears;
		w1(8'h18);
		repeat (5) @(posedge clk_sys_i);
		chk("fifo clears", 16'(c0 + 1), 16'(clears));
		chk("clock mode", 16'h0001, 16'(clock_mode_o));
		w1(8'h10);
		repeat (5) @(posedge clk_sys_i);
		chk("fifo clears", 16'(c0 + 2), 16'(clears));
		chk("clock mode", 16'h0002, 16'(clock_mode_o));
		chk("ref mode", 16'h0000, 16'(ref_mode_o));
		chk("shutdown", 16'h0001, 16'(shutdown_o));
		w1(8'h88);
		exp_q = '{ent(0, 0, 4'h0, 6'h01), ent(0, 0, 4'h1, 6'h01)};
		expect_scan();
	endtask

	task automatic t_readout();
		pops = 0;
		host.read_word(word);
		repeat (10) @(posedge clk_sys_i);
		chk("read word", 16'h0A5C, word);
		chk("fifo pops", 16'h0001, 16'(pops));
	endtask

	// ---------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------
	initial begin
		reset_i     = 1'b1;
		convst_n_i  = 1'b1;
		fifo_word_i = 12'hA5C;
		ack_delay   = 0;
		wait_n      = 0;
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		t_reset();
		t_range_temp();
		t_pairing();
		t_average();
		t_pin();
		t_reset_cmds();
		t_readout();
		final_report();
	end
endmodule
